/* include/mgp_pkg.sv */
// Constants, field layouts and carrier types of the multifunction pin bank.
// Assumes a 32-bit APB register port and a 200 MHz core clock.
package mgp_pkg;

    localparam int unsigned MGP_N_PINS = 16;
    localparam int unsigned MGP_N_REF  = 8;
    localparam int unsigned MGP_N_DPLL = 4;
    localparam int unsigned MGP_N_DCO  = 8;
    localparam int unsigned MGP_N_OUT  = 12;
    localparam int unsigned MGP_REF_IW  = 3;
    localparam int unsigned MGP_DPLL_IW = 2;
    localparam int unsigned MGP_DCO_IW  = 3;
    localparam int unsigned MGP_STK_W   = 2 * MGP_N_DPLL;
    localparam int unsigned MGP_AW      = 12;

    // Register map, byte addresses
    localparam logic [MGP_AW-1:0] MGP_PIN_SPAN   = 12'h080;
    localparam logic [MGP_AW-1:0] MGP_GLOB_CTRL  = 12'h080;
    localparam logic [MGP_AW-1:0] MGP_STICKY     = 12'h084;
    localparam logic [MGP_AW-1:0] MGP_ALERT_EN   = 12'h088;
    localparam logic [MGP_AW-1:0] MGP_GPI_STAT   = 12'h08C;
    localparam logic [MGP_AW-1:0] MGP_LIVE_STAT  = 12'h090;
    localparam int unsigned       MGP_PIDX_LSB   = 3;
    localparam int unsigned       MGP_PIDX_W     = 4;
    localparam int unsigned       MGP_WSEL_BIT   = 2;

    // Per-pin configuration word fields
    localparam int unsigned MGP_F_MODE = 0;
    localparam int unsigned MGP_F_EN   = 4;
    localparam int unsigned MGP_F_OD   = 5;
    localparam int unsigned MGP_F_PD   = 6;
    localparam int unsigned MGP_F_INV  = 7;
    localparam int unsigned MGP_F_LVL  = 8;
    localparam int unsigned MGP_F_SEL  = 12;
    localparam int unsigned MGP_SEL_W  = 4;
    localparam int unsigned MGP_F_GEN  = 0;

    typedef enum logic [3:0] {
        MGP_M_GPI       = 4'h0,
        MGP_M_GPO       = 4'h1,
        MGP_M_LOS       = 4'h2,
        MGP_M_LOL_LIVE  = 4'h3,
        MGP_M_LOL_STK   = 4'h4,
        MGP_M_HO_LIVE   = 4'h5,
        MGP_M_HO_STK    = 4'h6,
        MGP_M_ALERT     = 4'h7,
        MGP_M_OUT_DIS   = 4'h8,
        MGP_M_SE_CLK    = 4'h9,
        MGP_M_MAN_SEL   = 4'hA,
        MGP_M_INC       = 4'hB,
        MGP_M_DEC       = 4'hC,
        MGP_M_DISQ      = 4'hD
    } mgp_mode_t;

    typedef struct packed {
        logic [MGP_N_OUT-1:0] out_map;
        logic [MGP_SEL_W-1:0] sel;
        logic                 level;
        logic                 invert;
        logic                 pull_dn;
        logic                 open_drain;
        logic                 enable;
        mgp_mode_t            mode;
    } mgp_pin_cfg_t;

    localparam mgp_pin_cfg_t MGP_CFG_RST = '{
        out_map: '0, sel: '0, level: 1'b0, invert: 1'b0, pull_dn: 1'b0,
        open_drain: 1'b0, enable: 1'b1, mode: MGP_M_GPI};
    localparam logic MGP_GLOB_EN_RST = 1'b1;

    // Internal alarm sources feeding the pins
    typedef struct packed {
        logic [MGP_N_REF-1:0]  los;
        logic [MGP_N_DPLL-1:0] locked;
        logic [MGP_N_DPLL-1:0] holdover;
    } mgp_alarm_t;

    // Controls sent to the clock logic
    typedef struct packed {
        logic [MGP_N_OUT-1:0]  out_dis;
        logic [MGP_N_DPLL-1:0] man_act;
        logic [MGP_N_DPLL-1:0] man_hi;
        logic [MGP_N_DCO-1:0]  inc;
        logic [MGP_N_DCO-1:0]  dec;
        logic [MGP_N_REF-1:0]  disq;
        logic [MGP_N_PINS-1:0] se_en;
    } mgp_ctl_t;

    typedef struct packed {
        logic [MGP_N_PINS-1:0] s1;
        logic [MGP_N_PINS-1:0] s2;
        logic [MGP_N_PINS-1:0] s3;
        logic [MGP_N_PINS-1:0] rise;
    } mgp_sync_state_t;

endpackage

/* rtl/mgp_pin_sync.sv */
// Two-stage synchroniser and rising-edge detector for every pin.
// Assumes pins are asynchronous to clock; outputs are registered.
`timescale 1ns/1ps
module mgp_pin_sync
    import mgp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic [MGP_N_PINS-1:0] pin_i,
    output logic      [MGP_N_PINS-1:0] level_o,
    output logic      [MGP_N_PINS-1:0] rise_o
);

    mgp_sync_state_t st_q;
    mgp_sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        for (int i = 0; i < MGP_N_PINS; i++) begin
            st_d.s1[i]   = pin_i[i];
            st_d.s2[i]   = st_q.s1[i];
            st_d.s3[i]   = st_q.s2[i];
            st_d.rise[i] = st_q.s2[i] & ~st_q.s3[i];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.s2;
    assign rise_o  = st_q.rise;

    property p_rise_once;
        @(posedge clock) disable iff (!rst_b)
        rise_o[0] |=> !rise_o[0];
    endproperty
    a_rise_once: assert property (p_rise_once) // (R20)
        else $error("edge pulse lasted more than one cycle");

endmodule

/* rtl/mgp_gpio_bank.sv */
// Bank of multifunction pins with its APB register file.
// Assumes alarm sources and reset_done come from the same clock domain.
//
// Functional notes
// (R1) Each pin independently takes any function
// (R2) Functions act only after reset completes
// (R3) Unprogrammed pin defaults to general input
// (R4) Input level readable in status register
// (R5) Output pin drives register level
// (R6) Same alarm configuration gives same output
// (R7) LOS pin high on monitor alarm, invertible
// (R8) LOS output is live, never latched
// (R9) Live lock pin high when unlocked
// (R10) Sticky lock change held until cleared
// (R11) Live holdover pin high in holdover
// (R12) Sticky holdover change held until cleared
// (R13) Alert is OR of enabled sticky bits
// (R14) Alert holds until all bits cleared
// (R15) Alert active high, invertible
// (R16) High pin disables mapped output clocks
// (R17) Per-pin map picks any output subset
// (R18) Software avoids conflicting single-ended clock
// (R19) Pin level picks high or low reference
// (R20) Rising edge applies one increment
// (R21) Rising edge applies one decrement
// (R22) High pin disqualifies preset reference
// (R23) Enable, open-drain or push-pull drive
// (R24) Pull-up or pull-down, pull-up at reset
// (R25) Global enable gates all alarm sources
// (R26) Inputs synchronised before any use
`timescale 1ns/1ps
module mgp_gpio_bank
    import mgp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [MGP_AW-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  reset_done,
    input  wire mgp_alarm_t            alarm_i,
    input  wire logic [MGP_N_PINS-1:0] pin_i,
    output logic      [MGP_N_PINS-1:0] pin_o,
    output logic      [MGP_N_PINS-1:0] pin_oe,
    output logic      [MGP_N_PINS-1:0] pull_up_en,
    output logic      [MGP_N_PINS-1:0] pull_dn_en,
    output mgp_ctl_t                   ctl_o
);

    typedef struct packed {
        mgp_pin_cfg_t [MGP_N_PINS-1:0] cfg;
        logic                          glob_en;
        logic [MGP_STK_W-1:0]          sticky;
        logic [MGP_STK_W-1:0]          alert_en;
        logic [MGP_N_DPLL-1:0]         lock_prev;
        logic [MGP_N_DPLL-1:0]         ho_prev;
        logic [31:0]                   rdata;
        logic [MGP_N_PINS-1:0]         pin_o;
        logic [MGP_N_PINS-1:0]         pin_oe;
        logic [MGP_N_PINS-1:0]         pu;
        logic [MGP_N_PINS-1:0]         pd;
        mgp_ctl_t                      ctl;
    } mgp_bank_state_t;

    localparam mgp_bank_state_t MGP_BANK_RST = '{
        cfg: {MGP_N_PINS{MGP_CFG_RST}}, glob_en: MGP_GLOB_EN_RST,
        sticky: '0, alert_en: '0, lock_prev: '0, ho_prev: '0,
        rdata: '0, pin_o: '0, pin_oe: '0, pu: '1, pd: '0, ctl: '0};

    mgp_bank_state_t        st_q;
    mgp_bank_state_t        st_d;
    logic [MGP_N_PINS-1:0]  lvl;
    logic [MGP_N_PINS-1:0]  rise;
    logic [MGP_N_REF-1:0]   los_g;
    logic [MGP_N_DPLL-1:0]  nlock_g;
    logic [MGP_N_DPLL-1:0]  ho_g;
    logic [MGP_STK_W-1:0]   stk_ev;
    logic [MGP_STK_W-1:0]   stk_clr;
    logic                   alert;
    logic                   wr_en;
    logic                   rd_setup;
    logic                   pin_hit;
    logic                   mapped;
    logic [MGP_PIDX_W-1:0]  pidx;
    logic [MGP_N_PINS-1:0]  gpi_stat;

    mgp_pin_sync u_sync (
        .clock   (clock),
        .rst_b   (rst_b),
        .pin_i   (pin_i),
        .level_o (lvl),
        .rise_o  (rise)
    ); // (R26)

    // Alarm sources gated by the global enable
    assign los_g   = alarm_i.los & {MGP_N_REF{st_q.glob_en}}; // (R25)
    assign nlock_g = ~alarm_i.locked & {MGP_N_DPLL{st_q.glob_en}}; // (R25)
    assign ho_g    = alarm_i.holdover & {MGP_N_DPLL{st_q.glob_en}};
    assign stk_ev  = {alarm_i.holdover ^ st_q.ho_prev,
                      alarm_i.locked ^ st_q.lock_prev};
    assign alert   = |(st_q.sticky & st_q.alert_en); // (R13) (R14)

    // APB decode
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pin_hit  = paddr < MGP_PIN_SPAN;
    assign pidx     = paddr[MGP_PIDX_LSB +: MGP_PIDX_W];
    assign mapped   = (paddr[1:0] == 2'h0) &&
                      (pin_hit || paddr == MGP_GLOB_CTRL ||
                       paddr == MGP_STICKY || paddr == MGP_ALERT_EN ||
                       paddr == MGP_GPI_STAT || paddr == MGP_LIVE_STAT);
    assign stk_clr  = (wr_en && mapped && paddr == MGP_STICKY) ?
                      pwdata[MGP_STK_W-1:0] : '0;

    always_comb begin
        for (int i = 0; i < MGP_N_PINS; i++) begin
            gpi_stat[i] = lvl[i] & st_q.cfg[i].enable; // (R4)
        end
    end

    always_comb begin
        logic [31:0]  rd;
        mgp_pin_cfg_t c;
        logic         act;
        logic         val;
        logic         is_out;
        rd     = '0;
        c      = MGP_CFG_RST;
        act    = 1'b0;
        val    = 1'b0;
        is_out = 1'b0;
        st_d   = st_q;

        // Register reads, captured in the setup cycle
        c = st_q.cfg[pidx];
        if (pin_hit && !paddr[MGP_WSEL_BIT]) begin
            rd[MGP_F_MODE +: 4]         = c.mode;
            rd[MGP_F_EN]                = c.enable;
            rd[MGP_F_OD]                = c.open_drain;
            rd[MGP_F_PD]                = c.pull_dn;
            rd[MGP_F_INV]               = c.invert;
            rd[MGP_F_LVL]               = c.level;
            rd[MGP_F_SEL +: MGP_SEL_W]  = c.sel;
        end else if (pin_hit) begin
            rd[MGP_N_OUT-1:0] = c.out_map;
        end else if (paddr == MGP_GLOB_CTRL) begin
            rd[MGP_F_GEN] = st_q.glob_en;
        end else if (paddr == MGP_STICKY) begin
            rd[MGP_STK_W-1:0] = st_q.sticky;
        end else if (paddr == MGP_ALERT_EN) begin
            rd[MGP_STK_W-1:0] = st_q.alert_en;
        end else if (paddr == MGP_GPI_STAT) begin
            rd[MGP_N_PINS-1:0] = gpi_stat; // (R4)
        end else if (paddr == MGP_LIVE_STAT) begin
            rd[MGP_STK_W-1:0] = {ho_g, nlock_g};
        end
        if (rd_setup) begin
            st_d.rdata = mapped ? rd : '0;
        end

        // Register writes, taken in the access cycle
        if (wr_en && mapped) begin
            if (pin_hit && !paddr[MGP_WSEL_BIT]) begin
                st_d.cfg[pidx].mode       =
                    mgp_mode_t'(pwdata[MGP_F_MODE +: 4]); // (R1)
                st_d.cfg[pidx].enable     = pwdata[MGP_F_EN];
                st_d.cfg[pidx].open_drain = pwdata[MGP_F_OD];
                st_d.cfg[pidx].pull_dn    = pwdata[MGP_F_PD];
                st_d.cfg[pidx].invert     = pwdata[MGP_F_INV];
                st_d.cfg[pidx].level      = pwdata[MGP_F_LVL];
                st_d.cfg[pidx].sel        =
                    pwdata[MGP_F_SEL +: MGP_SEL_W];
            end else if (pin_hit) begin
                st_d.cfg[pidx].out_map = pwdata[MGP_N_OUT-1:0]; // (R17)
            end else if (paddr == MGP_GLOB_CTRL) begin
                st_d.glob_en = pwdata[MGP_F_GEN];
            end else if (paddr == MGP_ALERT_EN) begin
                st_d.alert_en = pwdata[MGP_STK_W-1:0];
            end
        end

        // Sticky change bits: a new event wins over a clear
        st_d.lock_prev = alarm_i.locked;
        st_d.ho_prev   = alarm_i.holdover;
        st_d.sticky    = (st_q.sticky & ~stk_clr) |
                         (stk_ev & {MGP_STK_W{st_q.glob_en}}); // (R10) (R12)

        // Per-pin function, shared sources keep equal pins equal (R6)
        st_d.ctl.out_dis = '0;
        st_d.ctl.man_act = '0;
        st_d.ctl.man_hi  = '0;
        st_d.ctl.inc     = '0;
        st_d.ctl.dec     = '0;
        st_d.ctl.disq    = '0;
        for (int i = 0; i < MGP_N_PINS; i++) begin
            c      = st_q.cfg[i];
            act    = reset_done & c.enable; // (R2) (R23)
            val    = 1'b0;
            is_out = 1'b1;
            case (c.mode)
                MGP_M_GPO: begin
                    val = c.level; // (R5)
                end
                MGP_M_LOS: begin
                    val = los_g[c.sel[MGP_REF_IW-1:0]] ^ c.invert; // (R7) (R8)
                end
                MGP_M_LOL_LIVE: begin
                    val = nlock_g[c.sel[MGP_DPLL_IW-1:0]] ^ c.invert; // (R9)
                end
                MGP_M_LOL_STK: begin
                    val = st_q.sticky[c.sel[MGP_DPLL_IW-1:0]]
                          ^ c.invert; // (R10)
                end
                MGP_M_HO_LIVE: begin
                    val = ho_g[c.sel[MGP_DPLL_IW-1:0]] ^ c.invert; // (R11)
                end
                MGP_M_HO_STK: begin
                    val = st_q.sticky[MGP_N_DPLL + 32'(c.sel[MGP_DPLL_IW-1:0])]
                          ^ c.invert; // (R12)
                end
                MGP_M_ALERT: begin
                    val = alert ^ c.invert; // (R15)
                end
                MGP_M_OUT_DIS: begin
                    is_out = 1'b0;
                    if (act && lvl[i]) begin
                        st_d.ctl.out_dis = st_d.ctl.out_dis
                                           | c.out_map; // (R16) (R17)
                    end
                end
                MGP_M_MAN_SEL: begin
                    is_out = 1'b0;
                    if (act) begin
                        st_d.ctl.man_act[c.sel[MGP_DPLL_IW-1:0]] = 1'b1;
                        if (lvl[i]) begin
                            st_d.ctl.man_hi[c.sel[MGP_DPLL_IW-1:0]] =
                                1'b1; // (R19)
                        end
                    end
                end
                MGP_M_INC: begin
                    is_out = 1'b0;
                    if (act && rise[i]) begin
                        st_d.ctl.inc[c.sel[MGP_DCO_IW-1:0]] = 1'b1; // (R20)
                    end
                end
                MGP_M_DEC: begin
                    is_out = 1'b0;
                    if (act && rise[i]) begin
                        st_d.ctl.dec[c.sel[MGP_DCO_IW-1:0]] = 1'b1; // (R21)
                    end
                end
                MGP_M_DISQ: begin
                    is_out = 1'b0;
                    if (act && lvl[i]) begin
                        st_d.ctl.disq[c.sel[MGP_REF_IW-1:0]] = 1'b1; // (R22)
                    end
                end
                default: begin
                    is_out = 1'b0; // (R3)
                end
            endcase
            st_d.ctl.se_en[i] = act && c.mode == MGP_M_SE_CLK;
            st_d.pin_o[i]  = c.open_drain ? 1'b0 : val; // (R23)
            st_d.pin_oe[i] = act & is_out &
                             (~c.open_drain | ~val); // (R23)
            st_d.pu[i]     = ~c.pull_dn; // (R24)
            st_d.pd[i]     = c.pull_dn; // (R24)
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= MGP_BANK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata     = st_q.rdata;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;
    assign pin_o      = st_q.pin_o;
    assign pin_oe     = st_q.pin_oe;
    assign pull_up_en = st_q.pu;
    assign pull_dn_en = st_q.pd;
    assign ctl_o      = st_q.ctl;

    // Checks, per-pin ones watched on pin 0
    mgp_pin_cfg_t c0;
    logic         act0;
    assign c0   = st_q.cfg[0];
    assign act0 = reset_done & c0.enable;

    property p_quiet;
        @(posedge clock) disable iff (!rst_b)
        !reset_done |=> pin_oe == '0 && ctl_o.inc == '0
                        && ctl_o.dec == '0;
    endproperty
    a_quiet: assert property (p_quiet) // (R2)
        else $error("pins active before reset done");

    property p_gpo;
        @(posedge clock) disable iff (!rst_b)
        act0 && c0.mode == MGP_M_GPO && !c0.open_drain
        |=> pin_oe[0] && pin_o[0] == $past(c0.level);
    endproperty
    a_gpo: assert property (p_gpo) // (R5)
        else $error("output pin not at register level");

    property p_los;
        @(posedge clock) disable iff (!rst_b)
        act0 && c0.mode == MGP_M_LOS && !c0.open_drain
        |=> pin_o[0] == ($past(los_g[c0.sel[MGP_REF_IW-1:0]])
                         ^ $past(c0.invert));
    endproperty
    a_los: assert property (p_los) // (R7)
        else $error("LOS pin does not follow monitor");

    property p_gpi;
        @(posedge clock) disable iff (!rst_b)
        rd_setup && paddr == MGP_GPI_STAT
        |=> prdata[MGP_N_PINS-1:0] == $past(gpi_stat);
    endproperty
    a_gpi: assert property (p_gpi) // (R4)
        else $error("input status read wrong");

    property p_stk_hold;
        @(posedge clock) disable iff (!rst_b)
        st_q.sticky[0] && !stk_clr[0] |=> st_q.sticky[0];
    endproperty
    a_stk_hold: assert property (p_stk_hold) // (R10)
        else $error("sticky bit lost without clear");

    property p_stk_set;
        @(posedge clock) disable iff (!rst_b)
        stk_ev[0] && st_q.glob_en |=> st_q.sticky[0];
    endproperty
    a_stk_set: assert property (p_stk_set) // (R10)
        else $error("lock change not recorded");

    property p_glob;
        @(posedge clock) disable iff (!rst_b)
        !st_q.glob_en |=> (st_q.sticky & ~$past(st_q.sticky)) == '0;
    endproperty
    a_glob: assert property (p_glob) // (R25)
        else $error("sticky set while alarms disabled");

    property p_alert;
        @(posedge clock) disable iff (!rst_b)
        act0 && c0.mode == MGP_M_ALERT && !c0.open_drain
        |=> pin_o[0] == ($past(alert) ^ $past(c0.invert));
    endproperty
    a_alert: assert property (p_alert) // (R13)
        else $error("alert pin wrong");

    property p_od;
        @(posedge clock) disable iff (!rst_b)
        c0.open_drain |=> pin_o[0] == 1'b0;
    endproperty
    a_od: assert property (p_od) // (R23)
        else $error("open-drain pin driven high");

    sequence s_inc_req;
        act0 && c0.mode == MGP_M_INC && rise[0];
    endsequence
    property p_inc;
        @(posedge clock) disable iff (!rst_b)
        s_inc_req ##1 1'b1
        |-> ctl_o.inc[$past(c0.sel[MGP_DCO_IW-1:0])];
    endproperty
    a_inc: assert property (p_inc) // (R20)
        else $error("increment pulse missing");

endmodule

/* test/mgp_pin_model.sv */
// Board-side model of the pin wires: resolves every pin level.
// Assumes the bench never drives a pin the bank is driving.
`timescale 1ns/1ps
module mgp_pin_model
    import mgp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic [MGP_N_PINS-1:0] pin_o,
    input  wire logic [MGP_N_PINS-1:0] pin_oe,
    input  wire logic [MGP_N_PINS-1:0] pull_up_en,
    input  wire logic [MGP_N_PINS-1:0] pull_dn_en,
    input  wire logic [MGP_N_PINS-1:0] ext_val,
    input  wire logic [MGP_N_PINS-1:0] ext_en,
    output logic      [MGP_N_PINS-1:0] pin_i
);
    logic [MGP_N_PINS-1:0] last_q;

    always_ff @(posedge clock) begin
        last_q <= pin_i;
    end

    // Released open-drain pins fall back to the pull; no pull floats
    always_comb begin
        for (int i = 0; i < MGP_N_PINS; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] :
                       ext_en[i] ? ext_val[i] :
                       pull_up_en[i] ? 1'b1 :
                       pull_dn_en[i] ? 1'b0 : ~last_q[i];
        end
    end
endmodule

/* test/multifunction_gpio_pins_tb.sv */
// Self-checking bench of the multifunction pin bank.
// Assumes the bank answers APB with pready and the pin model on its pins.
`timescale 1ns/1ps
module multifunction_gpio_pins_tb;
    import mgp_pkg::*;
    logic                  clock = 1'b0;
    logic                  rst_b, psel, penable, pwrite, reset_done;
    logic [MGP_AW-1:0]     paddr;
    logic [31:0]           pwdata, prdata, r;
    logic                  pready, pslverr, e;
    mgp_alarm_t            alarm;
    mgp_ctl_t              ctl_o;
    logic [MGP_N_PINS-1:0] pin_i, pin_o, pin_oe, pu, pd, ext_val, ext_en;
    int                    n_fail, cmp_count, cyc_n;

    mgp_gpio_bank dut_u (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_done(reset_done), .alarm_i(alarm),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pull_up_en(pu), .pull_dn_en(pd), .ctl_o(ctl_o));
    mgp_pin_model model_u (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
        .pull_up_en(pu), .pull_dn_en(pd), .ext_val(ext_val),
        .ext_en(ext_en), .pin_i(pin_i));

    always #2.5 clock = ~clock;

    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [MGP_AW-1:0] a,
                       input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [MGP_AW-1:0] a, input int b,
                          input logic exp);
        apb(1'b0, a, 32'h0);
        chk(32'(r[b]), 32'(exp));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Config word: mode, selector, {level, invert, pull_dn, open_drain}
    function automatic logic [31:0] cw(input logic [3:0] m,
                                       input logic [3:0] s,
                                       input logic [3:0] f);
        return 32'(m) | (32'h1 << MGP_F_EN) | (32'(f) << MGP_F_OD)
            | (32'(s) << MGP_F_SEL);
    endfunction

    function automatic logic [MGP_AW-1:0] pa(input int i);
        return MGP_AW'(8 * i);
    endfunction

    task automatic t_reset_gpo();
        chk(32'(pu), 32'hFFFF);
        chk(32'(pd), 32'h0);
        apb(1'b0, pa(0), 32'h0);
        chk(r, 32'h10);
        apb(1'b1, pa(1), cw(4'h1, 4'h0, 4'b1000));
        cyc(4);
        chk(32'(pin_oe[1]), 32'h0);
        reset_done <= 1'b1;
        cyc(3);
        chk(32'({pin_oe[1], pin_o[1]}), 32'h3);
        apb(1'b1, pa(2), cw(4'h1, 4'h0, 4'b0001));
        cyc(2);
        chk(32'({pin_oe[2], pin_o[2]}), 32'h2);
        apb(1'b1, pa(2), cw(4'h1, 4'h0, 4'b1001));
        cyc(2);
        chk(32'({pin_oe[2], pin_i[2]}), 32'h1);
        apb(1'b1, pa(2), cw(4'h0, 4'h0, 4'b0010));
        cyc(2);
        chk(32'({pu[2], pd[2]}), 32'h1);
    endtask

    task automatic t_gpi();
        ext_val[3] <= 1'b1;
        cyc(4);
        rd_chk(MGP_GPI_STAT, 3, 1'b1);
        ext_val[3] <= 1'b0;
        cyc(4);
        rd_chk(MGP_GPI_STAT, 3, 1'b0);
        apb(1'b0, 12'h0A0, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_los();
        apb(1'b1, pa(4), cw(4'h2, 4'h3, 4'b0000));
        apb(1'b1, pa(5), cw(4'h2, 4'h3, 4'b0000));
        apb(1'b1, pa(6), cw(4'h2, 4'h3, 4'b0100));
        alarm.los[3] <= 1'b1;
        cyc(3);
        chk(32'(pin_o[6:4]), 32'h3);
        alarm.los[3] <= 1'b0;
        cyc(3);
        chk(32'(pin_o[6:4]), 32'h4);
        apb(1'b1, MGP_GLOB_CTRL, 32'h0);
        alarm.los[3] <= 1'b1;
        cyc(3);
        chk(32'(pin_o[6:4]), 32'h4);
        apb(1'b1, MGP_GLOB_CTRL, 32'h1);
        alarm.los[3] <= 1'b0;
    endtask

    task automatic t_sticky();
        apb(1'b1, pa(7), cw(4'h3, 4'h1, 4'b0000));
        apb(1'b1, pa(8), cw(4'h4, 4'h1, 4'b0000));
        apb(1'b1, pa(9), cw(4'h5, 4'h2, 4'b0000));
        apb(1'b1, pa(10), cw(4'h6, 4'h2, 4'b0000));
        apb(1'b1, pa(11), cw(4'h7, 4'h0, 4'b0000));
        apb(1'b1, MGP_ALERT_EN, 32'h02);
        apb(1'b1, MGP_STICKY, 32'hFF);
        cyc(3);
        chk(32'(pin_o[11:7]), 32'h01);
        alarm.locked[1] <= 1'b1;
        cyc(3);
        chk(32'(pin_o[11:7]), 32'h12);
        alarm.holdover[2] <= 1'b1;
        cyc(3);
        chk(32'(pin_o[11:7]), 32'h1E);
        apb(1'b1, MGP_ALERT_EN, 32'h42);
        apb(1'b1, MGP_STICKY, 32'h02);
        cyc(3);
        chk(32'(pin_o[11:7]), 32'h1C);
        apb(1'b1, MGP_STICKY, 32'h40);
        cyc(3);
        chk(32'(pin_o[11:7]), 32'h04);
        apb(1'b1, pa(11), cw(4'h7, 4'h0, 4'b0100));
        cyc(3);
        chk(32'(pin_o[11]), 32'h1);
    endtask

    task automatic t_ctl();
        // Pin 0 feeds a stage that has no dedicated single-ended pair
        apb(1'b1, pa(0), cw(4'h9, 4'h0, 4'b0000));
        apb(1'b1, pa(12), cw(4'h8, 4'h0, 4'b0000));
        apb(1'b1, pa(12) + 12'h004, 32'hFFF);
        apb(1'b1, pa(13), cw(4'h8, 4'h0, 4'b0000));
        apb(1'b1, pa(13) + 12'h004, 32'h00A);
        apb(1'b1, pa(14), cw(4'hA, 4'h1, 4'b0000));
        apb(1'b1, pa(15), cw(4'hD, 4'h5, 4'b0000));
        ext_val[15:12] <= 4'b1101;
        cyc(5);
        chk(32'(ctl_o.se_en[0]), 32'h1);
        chk(32'(ctl_o.out_dis), 32'hFFF);
        chk(32'({ctl_o.man_act[1], ctl_o.man_hi[1]}), 32'h3);
        chk(32'(ctl_o.disq), 32'h20);
        ext_val[15:12] <= 4'b0010;
        cyc(5);
        chk(32'(ctl_o.out_dis), 32'h00A);
        chk(32'({ctl_o.man_act[1], ctl_o.man_hi[1]}), 32'h2);
        chk(32'(ctl_o.disq), 32'h0);
    endtask

    task automatic t_incdec();
        int n;
        for (int k = 0; k < 2; k++) begin
            // Pin 0 so that the bank's own increment check is exercised
            apb(1'b1, pa(0), cw(k ? 4'hC : 4'hB, 4'h2, 4'b0000));
            ext_val[0] <= 1'b0;
            cyc(6);
            n = 0;
            ext_val[0] <= 1'b1;
            repeat (10) begin
                cyc(1);
                if ((k ? ctl_o.dec[2] : ctl_o.inc[2]) === 1'b1)
                    n++;
            end
            chk(32'(n), 32'h1);
        end
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        reset_done = 1'b0;
        alarm = '0;
        ext_val = '0;
        ext_en = 16'hF009;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        cyc(1);
        t_reset_gpo();
        t_gpi();
        t_los();
        t_sticky();
        t_ctl();
        t_incdec();
        close_out();
    end
endmodule
